// *** rtl/irq_ipc_regs.vh ***
// register offsets, field positions, reset values for the dual-core irq block
`ifndef IRQ_IPC_REGS_VH
`define IRQ_IPC_REGS_VH

// byte offsets on the apb bus
`define OFS_IRQ_CONTROL_STATUS 8'h10
`define OFS_INTERPROC_TRIGGER 8'h14
`define OFS_IRQ_FLAG_CLEAR 8'h18
`define OFS_EVT_STATUS 8'h20
`define OFS_EVT_CLEAR 8'h24
`define OFS_EVT_ENABLE 8'h28

// irq_control_status field positions
`define CSR_IPC_FLAG_BIT 7
`define CSR_LEVEL_FLAG_BIT 6
`define CSR_FALL_FLAG_BIT 5
`define CSR_RISE_FLAG_BIT 4
`define CSR_IPC_EN_BIT 3
`define CSR_LEVEL_EN_BIT 2
`define CSR_FALL_EN_BIT 1
`define CSR_RISE_EN_BIT 0

// event status / enable / clear field positions
`define EVT_RISE_BIT 0
`define EVT_FALL_BIT 1
`define EVT_IPC_A_BIT 2
`define EVT_IPC_B_BIT 3

// reset and read-back values
`define ENABLE_RESET 4'h0
`define EVT_RESET 4'h0
`define FLAG_CLEAR_READ 8'hFF
`define READ_ZERO 32'h00000000

`endif

// *** rtl/pin_sync.v ***
// two-flop synchroniser for asynchronous input pins
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // meta_q is read only by sync_q
  always @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync_out = sync_q;
endmodule

// *** rtl/core_irq_slice.v ***
// per-core enable bits, inter-processor flag and irq request
`timescale 1ns/10ps
`include "irq_ipc_regs.vh"
module core_irq_slice (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire en_we,
  input wire [3:0] en_wdata,
  input wire ipc_set,
  input wire ipc_clr,
  input wire level_flag,
  input wire fall_flag,
  input wire rise_flag,
  output wire [3:0] enable,
  output wire ipc_flag,
  output wire irq_n
);
  reg [3:0] en_q;
  reg ipc_q;
  reg irq_n_q;
  wire [3:0] flags;

  assign flags = {ipc_q, level_flag, fall_flag, rise_flag};

  always @(posedge clk) begin
    if (!rstn) begin
      en_q <= `ENABLE_RESET;
      ipc_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else if (ce) begin
      if (en_we)
        en_q <= en_wdata;
      // set beats a clear landing in the same cycle
      if (ipc_set)
        ipc_q <= 1'b1;
      else if (ipc_clr)
        ipc_q <= 1'b0;
      // each flag gated by its own enable; ipc obeys the same gate
      irq_n_q <= ~|(flags & en_q);
    end
  end

  assign enable = en_q;
  assign ipc_flag = ipc_q;
  assign irq_n = irq_n_q;
endmodule

// *** rtl/dual_cpu_irq_ipc.v ***
// dual-core interrupt control/status, flag clear and inter-processor trigger over apb
`timescale 1ns/10ps
`include "irq_ipc_regs.vh"
module dual_cpu_irq_ipc #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pcore,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rising_edge_irq_pin,
  input wire falling_edge_irq_pin,
  input wire level_irq_pin,
  output wire irq_core_a_n,
  output wire irq_core_b_n,
  output wire irq
);
  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_CSR = 3'h1;
  localparam [2:0] SEL_TRIG = 3'h2;
  localparam [2:0] SEL_CLR = 3'h3;
  localparam [2:0] SEL_EST = 3'h4;
  localparam [2:0] SEL_ECLR = 3'h5;
  localparam [2:0] SEL_EEN = 3'h6;

  // any set bit above the low byte leaves the access unmapped, so no alias
  // of the map shows up higher when the address bus is widened
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    reg high_zero;
    begin
      high_zero = ((addr >> 8) == {ADDR_W{1'b0}});
      reg_sel = SEL_NONE;
      if (high_zero) begin
        case (addr[7:0])
          `OFS_IRQ_CONTROL_STATUS: reg_sel = SEL_CSR;
          `OFS_INTERPROC_TRIGGER: reg_sel = SEL_TRIG;
          `OFS_IRQ_FLAG_CLEAR: reg_sel = SEL_CLR;
          `OFS_EVT_STATUS: reg_sel = SEL_EST;
          `OFS_EVT_CLEAR: reg_sel = SEL_ECLR;
          `OFS_EVT_ENABLE: reg_sel = SEL_EEN;
          default: reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // edge test shared by both edge pins; rising picks the polarity
  function edge_seen;
    input now;
    input prev;
    input rising;
    begin
      if (rising)
        edge_seen = now & ~prev;
      else
        edge_seen = ~now & prev;
    end
  endfunction

  function [7:0] csr_view;
    input ipc;
    input lvl;
    input fall;
    input rise;
    input [3:0] en;
    begin
      csr_view = {ipc, lvl, fall, rise, en};
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  reg rise_prev_q;
  reg fall_prev_q;
  reg level_q;
  reg rise_flag_q;
  reg fall_flag_q;

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h7)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin_in({level_irq_pin, falling_edge_irq_pin, rising_edge_irq_pin}),
    .pin_sync_out(pins_s)
  );

  wire rise_pin_s = pins_s[0];
  wire fall_pin_s = pins_s[1];
  wire level_pin_s = pins_s[2];
  // history flops start high like the synchronisers, so release shows no edge
  wire rise_evt = edge_seen(rise_pin_s, rise_prev_q, 1'b1);
  wire fall_evt = edge_seen(fall_pin_s, fall_prev_q, 1'b0);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;

  // one wait state so read data and pready come from flops
  wire access = psel & penable & ~pready_q;
  wire commit = psel & penable & pready_q & ~pslverr_q;
  wire wr = commit & pwrite;

  // map, byte addresses, one word each, data in the low byte:
  //   0x10 control/status, per core: ipc flag, level, fall, rise, then
  //        the core's own ipc/level/fall/rise enables in bits 3..0
  //   0x14 trigger, write only: raises the other core's ipc flag
  //   0x18 flag clear: a zero in bit 7, 5 or 4 clears that flag; reads ones
  //   0x20 event status, 0x24 event clear (write one), 0x28 event enable
  wire [2:0] sel = reg_sel(paddr);
  wire hit_csr = (sel == SEL_CSR);
  wire hit_trig = (sel == SEL_TRIG);
  wire hit_clr = (sel == SEL_CLR);
  wire hit_eclr = (sel == SEL_ECLR);
  wire hit_een = (sel == SEL_EEN);
  wire mapped = (sel != SEL_NONE);

  // ----------------------------------------------------------------
  // shared edge and level flags
  // ----------------------------------------------------------------
  wire clr_wr = wr & hit_clr;
  wire rise_clr = clr_wr & ~pwdata[`CSR_RISE_FLAG_BIT];
  wire fall_clr = clr_wr & ~pwdata[`CSR_FALL_FLAG_BIT];

  always @(posedge clk) begin
    if (!rstn) begin
      rise_prev_q <= 1'b1;
      fall_prev_q <= 1'b1;
      level_q <= 1'b0;
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else if (ce) begin
      rise_prev_q <= rise_pin_s;
      fall_prev_q <= fall_pin_s;
      // software has no path to this flag
      level_q <= ~level_pin_s;
      if (rise_evt)
        rise_flag_q <= 1'b1;
      else if (rise_clr)
        rise_flag_q <= 1'b0;
      if (fall_evt)
        fall_flag_q <= 1'b1;
      else if (fall_clr)
        fall_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-core slices (index 0 = core a, 1 = core b)
  // ----------------------------------------------------------------
  wire [3:0] en_c [0:1];
  wire [1:0] ipc_c;
  wire [1:0] irq_n_c;
  wire [1:0] ipc_set_c;
  wire [1:0] en_we_c;
  wire [1:0] ipc_clr_c;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_core
      wire mine = (pcore == g);
      // the writing core triggers the opposite core
      assign ipc_set_c[g] = wr & hit_trig & ~mine;
      // each core writes and clears only its own copy
      assign en_we_c[g] = wr & hit_csr & mine;
      assign ipc_clr_c[g] = clr_wr & mine & ~pwdata[`CSR_IPC_FLAG_BIT];
      core_irq_slice u_slice (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .en_we(en_we_c[g]),
        .en_wdata(pwdata[3:0]),
        .ipc_set(ipc_set_c[g]),
        .ipc_clr(ipc_clr_c[g]),
        .level_flag(level_q),
        .fall_flag(fall_flag_q),
        .rise_flag(rise_flag_q),
        .enable(en_c[g]),
        .ipc_flag(ipc_c[g]),
        .irq_n(irq_n_c[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // sticky event status, clear and enable
  // ----------------------------------------------------------------
  reg [3:0] evt_q;
  reg [3:0] evt_en_q;
  reg irq_q;
  wire [3:0] evt_set;
  wire [3:0] evt_clr;

  assign evt_set[`EVT_RISE_BIT] = rise_evt;
  assign evt_set[`EVT_FALL_BIT] = fall_evt;
  assign evt_set[`EVT_IPC_A_BIT] = ipc_set_c[0];
  assign evt_set[`EVT_IPC_B_BIT] = ipc_set_c[1];
  // write one to clear, so a read-modify-write cannot drop a fresh event
  assign evt_clr = (wr & hit_eclr) ? pwdata[3:0] : 4'h0;

  always @(posedge clk) begin
    if (!rstn) begin
      evt_q <= `EVT_RESET;
      evt_en_q <= `EVT_RESET;
      irq_q <= 1'b0;
    end else if (ce) begin
      // a new event outranks a clear in the same cycle
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (wr & hit_een)
        evt_en_q <= pwdata[3:0];
      // registered so irq leaves a flop; it trails the status by one cycle
      irq_q <= |(evt_q & evt_en_q);
    end
  end

  // ----------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------
  reg [31:0] rdata;
  always @* begin
    rdata = `READ_ZERO;
    case (sel)
      SEL_CSR: begin
        // each core sees its own ipc flag and enables at the one address
        rdata = {24'h000000, csr_view(ipc_c[pcore], level_q, fall_flag_q, rise_flag_q,
                                      en_c[pcore])};
      end
      SEL_CLR: begin
        rdata = {24'h000000, `FLAG_CLEAR_READ};
      end
      SEL_EST: begin
        rdata = {28'h0000000, evt_q};
      end
      SEL_EEN: begin
        rdata = {28'h0000000, evt_en_q};
      end
      default: begin
        // trigger and event clear hold nothing to read back
        rdata = `READ_ZERO;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `READ_ZERO;
    end else if (ce) begin
      pready_q <= access;
      // an unmapped word still answers, flagged by pslverr
      pslverr_q <= access & ~mapped;
      if (access & ~pwrite)
        prdata_q <= rdata;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_core_a_n = irq_n_c[0];
  assign irq_core_b_n = irq_n_c[1];
  assign irq = irq_q;
endmodule

// *** tb/irq_ipc_assertions.sv ***
// port-level checks for the dual-core interrupt block
`timescale 1ns/10ps
module irq_ipc_assertions #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pcore,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq_core_a_n,
  input wire irq_core_b_n
);
  logic en_a_q, en_b_q, ipc_b_q;
  wire done = psel && penable && pready;
  wire csr_wr = done && pwrite && paddr == 8'h10;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // tracks whether any enable is on, enough to prove a quiet core, and core b's ipc enable for the trigger check
  always @(posedge clk) begin
    if (!rstn) begin
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
      ipc_b_q <= 1'b0;
    end else if (csr_wr && !pcore) begin
      en_a_q <= |pwdata[3:0];
    end else if (csr_wr) begin
      en_b_q <= |pwdata[3:0];
      ipc_b_q <= pwdata[3];
    end
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  pready_cause_a: assert property ($rose(pready) |-> $past(psel) && $past(penable))
    else $error("pready without access");
  decode_err_a: assert property (pready |->
    pslverr == !(paddr inside {8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28}))
    else $error("pslverr wrong");
  clear_read_a: assert property (done && !pwrite && paddr == 8'h18 |->
    prdata == 32'h000000FF) else $error("clear location read wrong");
  trig_read_a: assert property (done && !pwrite && paddr == 8'h14 |->
    prdata == 32'h0) else $error("trigger location read wrong");
  quiet_core_a_a: assert property (!en_a_q && !$past(en_a_q) && !$past(en_a_q, 2) |->
    irq_core_a_n) else $error("core a irq while disabled");
  quiet_core_b_a: assert property (!en_b_q && !$past(en_b_q) && !$past(en_b_q, 2) |->
    irq_core_b_n) else $error("core b irq while disabled");
  ipc_trigger_a: assert property (done && pwrite && paddr == 8'h14 && !pcore && ipc_b_q |->
    ##[1:3] !irq_core_b_n) else $error("trigger did not reach core b");
endmodule

// *** tb/irq_pin_source.sv ***
// far-side model driving the three interrupt pins
`timescale 1ns/10ps
module irq_pin_source (
  input wire clk,
  input wire [2:0] want,
  output logic [2:0] pins
);
  initial begin
    pins = 3'b110;
  end
  // pins move on an edge, unrelated to any bus transfer
  always @(posedge clk) begin
    pins <= want;
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the dual-core interrupt block
`timescale 1ns/10ps
module tb;
  logic clk, rstn, ce, psel, penable, pwrite, who;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [2:0] want;
  wire [31:0] prdata;
  wire pready, pslverr, irq_a_n, irq_b_n, irq;
  wire [2:0] pins;
  logic [31:0] expq[$];
  int mismatches, cmp_count, seed, n;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  dual_cpu_irq_ipc dual_cpu_irq_ipc_inst (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pcore(who),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rising_edge_irq_pin(pins[0]),
    .falling_edge_irq_pin(pins[1]), .level_irq_pin(pins[2]), .irq_core_a_n(irq_a_n),
    .irq_core_b_n(irq_b_n), .irq(irq));
  irq_pin_source irq_pin_source_inst (.clk(clk), .want(want), .pins(pins));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a read carries its expected word in d, noted before the answer comes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    psel <= 1'b1;
    if (!w) expq.push_back(d);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task irqs(input logic [2:0] e);
    repeat (2) @(posedge clk);
    chk("irq lines", {29'h0, e}, {29'h0, irq, irq_a_n, irq_b_n});
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", expq.pop_front(), prdata);
    end
  end
  initial begin
    seed = 32'h0786;
    {rstn, psel, penable, pwrite, who} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 3'b110;
    ce = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    apb(1'b0, 8'h18, 32'hFF);
    apb(1'b0, 8'h14, 32'h0);
    apb(1'b1, 8'h30, $random(seed));
    apb(1'b1, 8'h10, 32'h8);
    who <= 1'b1;
    apb(1'b1, 8'h10, 32'h8);
    who <= 1'b0;
    apb(1'b1, 8'h14, $random(seed));
    irqs(3'b010);
    apb(1'b0, 8'h10, 32'h08);
    apb(1'b1, 8'h18, 32'h0);
    who <= 1'b1;
    apb(1'b0, 8'h10, 32'h88);
    apb(1'b1, 8'h18, 32'h7F);
    apb(1'b0, 8'h10, 32'h08);
    apb(1'b1, 8'h10, 32'h0);
    who <= 1'b0;
    apb(1'b1, 8'h14, $random(seed));
    irqs(3'b011);
    who <= 1'b1;
    apb(1'b0, 8'h10, 32'h80);
    apb(1'b1, 8'h18, 32'h7F);
    who <= 1'b0;
    $display("ipc test done");
    apb(1'b1, 8'h10, 32'h3);
    want <= 3'b111;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h10, 32'h13);
    irqs(3'b001);
    want <= 3'b101;
    repeat (6) @(posedge clk);
    who <= 1'b1;
    apb(1'b0, 8'h10, 32'h30);
    apb(1'b1, 8'h18, 32'hDF);
    who <= 1'b0;
    apb(1'b0, 8'h10, 32'h13);
    apb(1'b1, 8'h18, 32'hEF);
    irqs(3'b011);
    $display("edge test done");
    want <= 3'b001;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h10, 32'h43);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b0, 8'h10, 32'h43);
    irqs(3'b011);
    apb(1'b1, 8'h10, 32'h4);
    irqs(3'b001);
    want <= 3'b101;
    repeat (6) @(posedge clk);
    irqs(3'b011);
    ce <= 1'b0;
    want <= 3'b001;
    repeat (6) @(posedge clk);
    irqs(3'b011);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    irqs(3'b001);
    want <= 3'b101;
    repeat (6) @(posedge clk);
    $display("level test done");
    apb(1'b0, 8'h20, 32'hB);
    apb(1'b1, 8'h28, 32'h1);
    irqs(3'b111);
    apb(1'b1, 8'h28, 32'h0);
    irqs(3'b011);
    apb(1'b1, 8'h28, 32'h1);
    apb(1'b1, 8'h24, 32'h1);
    irqs(3'b011);
    apb(1'b1, 8'h20, 32'hF);
    apb(1'b0, 8'h20, 32'hA);
    apb(1'b0, 8'h28, 32'h1);
    $display("event test done");
    conclude();
  end
endmodule
bind dual_cpu_irq_ipc irq_ipc_assertions #(.ADDR_W(ADDR_W)) irq_ipc_assertions_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pcore(pcore), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_core_a_n(irq_core_a_n), .irq_core_b_n(irq_core_b_n));
